// [pkg/phy_mode_cfg_pkg.sv]
// package: offsets, field layout, reset values and carriers of the mode bank
package phy_mode_cfg_pkg;
  // port count and width of the port index; port 0 is the upstream port
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 3;
  localparam logic [PORT_W-1:0] UP_PORT = 3'h0;

  // register offsets
  localparam logic [7:0] OFS_PORT_TUNING = 8'h8c;
  localparam logic [7:0] OFS_PHY_LANE_DELTA = 8'h90;
  localparam logic [7:0] OFS_PHY_TX_MARGIN = 8'h94;
  localparam logic [7:0] OFS_OPMODE_CLKBUF = 8'h98;

  // port tuning word layout
  localparam int POS_PORT_OFF = 0;
  localparam int POS_RESET_CHOICE = 1;
  localparam int POS_TUNING_LO = 8;
  localparam int POS_TS_REV_LO = 16;
  localparam logic [31:0] MASK_PORT_TUNING = 32'h00ff_ff03;
  localparam logic [7:0] RST_TUNING = 8'h00;
  localparam logic [7:0] RST_TS_REV = 8'h79;

  // phy lane and delta layout
  localparam int POS_LANE_LO = 0;
  localparam int POS_DELTA_LO = 15;
  localparam logic [31:0] MASK_PHY_LANE_DELTA = 32'hffff_807f;
  localparam logic [6:0] RST_LANE_MODE = 7'h00;
  localparam logic [16:0] RST_DELTA = 17'h0_0001;

  // transmit margin layout
  localparam logic [31:0] MASK_PHY_TX_MARGIN = 32'h0000_ffff;
  localparam logic [15:0] RST_TX_MARGIN = 16'h116b;

  // operation mode and clock buffer layout
  localparam int POS_CLKEN_LO = 16;
  localparam int POS_CLKBUF_OFF = 23;
  localparam int POS_LPSS_LO = 24;
  localparam logic [31:0] MASK_OPMODE_CLKBUF = 32'h0fff_01ff;
  localparam logic [15:0] RST_OPMODE_505 = 16'h0002;
  localparam logic [15:0] RST_OPMODE_606 = 16'h0022;
  localparam logic [15:0] RST_OPMODE_508 = 16'h0042;
  localparam logic [6:0] RST_CLKEN_606 = 7'h7f;
  localparam logic [6:0] RST_CLKEN_OTHER = 7'h5f;
  localparam logic [3:0] RST_LPSS = 4'h0;

  // variant strap codes
  localparam logic [1:0] VAR_505 = 2'h0;
  localparam logic [1:0] VAR_606 = 2'h1;
  localparam logic [1:0] VAR_508 = 2'h2;

  // host configuration access
  typedef struct packed {
    logic rd;
    logic wr;
    logic [PORT_W-1:0] port;
    logic [7:0] offset;
    logic [31:0] wdata;
  } cfg_req_s;

  // sideband load (smbus, i2c or eeprom autoload)
  typedef struct packed {
    logic wr;
    logic [PORT_W-1:0] port;
    logic [7:0] offset;
    logic [31:0] data;
  } sb_load_s;
endpackage : phy_mode_cfg_pkg

// [logic/phy_mode_cfg_bank.sv]
// logic: per-port phy and operation mode configuration bank
module phy_mode_cfg_bank
  import phy_mode_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // strap pins
  input wire logic [1:0] variant_strap,
  input wire logic refclk_buffer_powerdown_strap,
  // host configuration access
  input wire cfg_req_s cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata_r,
  // sideband load path
  input wire sb_load_s sb_load,
  // configuration outputs
  output logic [NUM_PORTS-1:0] port_off,
  output logic reset_source_choice,
  output logic [NUM_PORTS-1:0] retrain_off,
  output logic [NUM_PORTS*7-1:0] phy_lane_mode,
  output logic [16:0] phy_delta,
  output logic [15:0] phy_tx_margin,
  output logic [15:0] operation_mode,
  output logic [6:0] reference_clock_output_pair_en,
  output logic [3:0] low_power_substate_option
);

  // strap synchronisers, three stages
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [2:0] strap_s3_r;
  logic [2:0] strap_r; // filtered strap levels
  // per-port copies
  logic [31:0] tuning_r [NUM_PORTS]; // port tuning word
  logic [31:0] lane_delta_r [NUM_PORTS]; // lane mode and delta
  // upstream-only words
  logic [15:0] tx_margin_r;
  logic [31:0] opmode_r;
  // reset values that depend on straps
  logic [15:0] opmode_rst;
  logic [6:0] clken_rst;

  // word read back for a port and offset, reserved bits zero
  function automatic logic [31:0] read_word(input logic [PORT_W-1:0] p,
                                            input logic [7:0] ofs);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (ofs)
      OFS_PORT_TUNING: w = tuning_r[p] & MASK_PORT_TUNING;
      OFS_PHY_LANE_DELTA: w = lane_delta_r[p] & MASK_PHY_LANE_DELTA;
      OFS_PHY_TX_MARGIN: w = {16'h0000, tx_margin_r};
      OFS_OPMODE_CLKBUF: w = opmode_r & MASK_OPMODE_CLKBUF;
      default: w = 32'h0000_0000; // unmapped reads zero
    endcase
    return w;
  endfunction : read_word

  // sideband write hits this port and offset
  function automatic logic sb_hit(input logic [PORT_W-1:0] p, input logic [7:0] ofs);
    return sb_load.wr && (sb_load.port == p) && (sb_load.offset == ofs);
  endfunction : sb_hit

  // strap pins cross in through three flops, no reset needed on the chain
  always_ff @(posedge ref_clk)
  begin
    strap_s1_r <= {refclk_buffer_powerdown_strap, variant_strap};
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
  end

  // filtered strap moves only when stages two and three agree
  // keeps tracking during reset, else the reset defaults would never see the pins
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (strap_s2_r[i] == strap_s3_r[i]) // stages agree
        strap_r[i] <= strap_s3_r[i];
    end
  end

  // strap-derived defaults of operation mode and clock enables
  always_comb
  begin
    case (strap_r[1:0])
      VAR_606: // six-port variant
      begin
        opmode_rst = RST_OPMODE_606;
        clken_rst = RST_CLKEN_606;
      end
      VAR_508: // five-port eight-lane variant
      begin
        opmode_rst = RST_OPMODE_508;
        clken_rst = RST_CLKEN_OTHER;
      end
      default: // five-port five-lane variant
      begin
        opmode_rst = RST_OPMODE_505;
        clken_rst = RST_CLKEN_OTHER;
      end
    endcase
  end

  // per-port copies, loaded only from the sideband path
  generate
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
      localparam logic [PORT_W-1:0] PIDX = PORT_W'(g);
      // tuning word per port
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          tuning_r[g] <= '0;
          tuning_r[g][POS_PORT_OFF] <= 1'b0;
          tuning_r[g][POS_RESET_CHOICE] <= (g == 0);
          tuning_r[g][POS_TUNING_LO +: 8] <= RST_TUNING;
          tuning_r[g][POS_TS_REV_LO +: 8] <= RST_TS_REV;
        end
        else if (sb_hit(PIDX, OFS_PORT_TUNING))
          tuning_r[g] <= sb_load.data & MASK_PORT_TUNING;
      end
      // lane mode and delta per port
      always_ff @(posedge ref_clk)
      begin
        if (!nrst)
        begin
          lane_delta_r[g] <= '0;
          lane_delta_r[g][POS_LANE_LO +: 7] <= RST_LANE_MODE;
          lane_delta_r[g][POS_DELTA_LO +: 17] <= RST_DELTA;
        end
        else if (sb_hit(PIDX, OFS_PHY_LANE_DELTA))
          lane_delta_r[g] <= sb_load.data & MASK_PHY_LANE_DELTA;
      end
      // per-port outputs
      assign port_off[g] = tuning_r[g][POS_PORT_OFF];
      assign retrain_off[g] = tuning_r[g][POS_TUNING_LO];
      assign phy_lane_mode[g*7 +: 7] = lane_delta_r[g][POS_LANE_LO +: 7];
    end
  endgenerate

  // transmit margin, upstream copy only
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      tx_margin_r <= RST_TX_MARGIN;
    else if (sb_hit(UP_PORT, OFS_PHY_TX_MARGIN))
      tx_margin_r <= sb_load.data[15:0];
  end

  // operation mode and clock buffers, defaults from filtered straps
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      opmode_r <= '0;
      opmode_r[15:0] <= opmode_rst;
      opmode_r[POS_CLKEN_LO +: 7] <= clken_rst;
      opmode_r[POS_CLKBUF_OFF] <= strap_r[2];
      opmode_r[POS_LPSS_LO +: 4] <= RST_LPSS;
    end
    else if (sb_hit(UP_PORT, OFS_OPMODE_CLKBUF))
      opmode_r <= sb_load.data & MASK_OPMODE_CLKBUF;
  end

  // global outputs, upstream copy only
  assign reset_source_choice = tuning_r[0][POS_RESET_CHOICE];
  assign phy_delta = lane_delta_r[0][POS_DELTA_LO +: 17];
  assign phy_tx_margin = tx_margin_r;
  assign operation_mode = opmode_r[15:0];
  assign low_power_substate_option = opmode_r[POS_LPSS_LO +: 4];
  // global gate overrides per-pair enables
  assign reference_clock_output_pair_en = opmode_r[POS_CLKBUF_OFF] ? 7'h00 :
                                          opmode_r[POS_CLKEN_LO +: 7];

  // host access answers every request next cycle; writes change nothing
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cfg_ack <= 1'b0;
      cfg_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack <= cfg_req.rd | cfg_req.wr;
      if (cfg_req.rd)
        cfg_rdata_r <= read_word(cfg_req.port, cfg_req.offset);
    end
  end

endmodule : phy_mode_cfg_bank

// [verif/phy_mode_cfg_bank_asserts.sv]
// checker: timing and load relations at the mode bank ports
module phy_mode_cfg_bank_asserts
  import phy_mode_cfg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // requests
  input wire cfg_req_s cfg_req,
  input wire sb_load_s sb_load,
  // watched outputs
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata_r,
  input wire logic [NUM_PORTS-1:0] port_off,
  input wire logic [NUM_PORTS-1:0] retrain_off,
  input wire logic [16:0] phy_delta,
  input wire logic [15:0] phy_tx_margin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // host request and sideband load strobes
  wire hreq = cfg_req.rd | cfg_req.wr;
  wire ld = sb_load.wr;
  wire up = sb_load.port == UP_PORT;
  wire tun = ld && sb_load.offset == OFS_PORT_TUNING && sb_load.port < NUM_PORTS;
  // reset held across two edges
  sequence rst_two;
    !nrst ##1 !nrst;
  endsequence
  ack_after_a: assert property (hreq |=> cfg_ack) else $error("ack missing");
  ack_only_a: assert property (!hreq |=> !cfg_ack) else $error("stray ack");
  wr_ignored_a:
    assert property (cfg_req.wr && !ld |=> $stable(port_off) && $stable(phy_delta)
      && $stable(phy_tx_margin)) else $error("host write changed field");
  rsv_zero_a:
    assert property (cfg_req.rd && cfg_req.offset == OFS_PHY_TX_MARGIN
      |=> cfg_rdata_r[31:16] == 16'h0) else $error("reserved bits set");
  delta_up_a:
    assert property (ld && sb_load.offset == OFS_PHY_LANE_DELTA && up
      |=> phy_delta == $past(sb_load.data[31:15])) else $error("delta load");
  delta_down_a:
    assert property (ld && sb_load.offset == OFS_PHY_LANE_DELTA && !up
      |=> $stable(phy_delta)) else $error("delta from downstream");
  off_load_a:
    assert property (tun |=> port_off[$past(sb_load.port)] == $past(sb_load.data[0]))
      else $error("port off load");
  retrain_a:
    assert property (tun |=> retrain_off[$past(sb_load.port)] == $past(sb_load.data[8]))
      else $error("retrain load");
  margin_a:
    assert property (ld && sb_load.offset == OFS_PHY_TX_MARGIN && up
      |=> phy_tx_margin == $past(sb_load.data[15:0])) else $error("margin load");
  rst_val_a:
    assert property (disable iff (1'b0) rst_two |-> port_off == '0
      && phy_delta == RST_DELTA && phy_tx_margin == RST_TX_MARGIN && !cfg_ack)
      else $error("reset values");
endmodule : phy_mode_cfg_bank_asserts

bind phy_mode_cfg_bank phy_mode_cfg_bank_asserts chk (.ref_clk(ref_clk), .nrst(nrst),
  .cfg_req(cfg_req), .sb_load(sb_load), .cfg_ack(cfg_ack), .cfg_rdata_r(cfg_rdata_r),
  .port_off(port_off), .retrain_off(retrain_off), .phy_delta(phy_delta),
  .phy_tx_margin(phy_tx_margin));

// [verif/switch_phy_mode_config_bank_bench.sv]
// bench: directed scenarios for the mode bank
module switch_phy_mode_config_bank_bench
  import phy_mode_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus
  logic ref_clk = 0, nrst = 0, pd = 0;
  logic [1:0] vs = 0;
  cfg_req_s q = '0;
  sb_load_s s = '0;
  // observed outputs
  logic cfg_ack, rsc;
  logic [31:0] rdata;
  logic [5:0] port_off, retrain_off;
  logic [41:0] lane;
  logic [16:0] delta;
  logic [15:0] margin, opm;
  logic [6:0] clken;
  logic [3:0] lpss;
  int error_cnt = 0, checked = 0;
  // 0x98 word per strap code, pd set on odd codes
  localparam logic [31:0] EV[4] = '{32'h005f_0002, 32'h00ff_0022, 32'h005f_0042, 32'h00df_0002};
  phy_mode_cfg_bank uut (.ref_clk(ref_clk), .nrst(nrst), .variant_strap(vs),
    .refclk_buffer_powerdown_strap(pd), .cfg_req(q), .cfg_ack(cfg_ack), .cfg_rdata_r(rdata),
    .sb_load(s), .port_off(port_off), .reset_source_choice(rsc), .retrain_off(retrain_off),
    .phy_lane_mode(lane), .phy_delta(delta), .phy_tx_margin(margin), .operation_mode(opm),
    .reference_clock_output_pair_en(clken), .low_power_substate_option(lpss));
  // 50 MHz clock
  initial forever #10 ref_clk = ~ref_clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // reset with given straps, held 6 cycles
  task rst(input logic [1:0] v, input logic p);
    @(posedge ref_clk);
    vs <= v;
    pd <= p;
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask : rst
  // host access: one-cycle strobe, ack one cycle later
  task acc(input logic w, input logic [2:0] p, input logic [7:0] o, input logic [31:0] d);
    @(posedge ref_clk);
    q <= '{~w, w, p, o, w ? d : 32'h0};
    @(posedge ref_clk);
    q <= '0;
    #1 chk("ack", 32'h1, {31'h0, cfg_ack});
    if (!w) chk("rdata", d, rdata);
  endtask : acc
  // sideband load, visible after the taking edge
  task sb(input logic [2:0] p, input logic [7:0] o, input logic [31:0] d);
    @(posedge ref_clk);
    s <= '{1'b1, p, o, d};
    @(posedge ref_clk);
    s <= '0;
    #1;
  endtask : sb
  task t_defaults;
    rst(VAR_606, 1'b0);
    acc(0, 0, OFS_PORT_TUNING, 32'h0079_0002);
    acc(0, 1, OFS_PORT_TUNING, 32'h0079_0000);
    acc(0, 0, OFS_PHY_LANE_DELTA, 32'h0000_8000);
    acc(0, 0, OFS_PHY_TX_MARGIN, 32'h0000_116b);
    acc(0, 2, OFS_OPMODE_CLKBUF, 32'h007f_0022);
    acc(0, 0, 8'h9c, 32'h0);
    chk("rsc", 32'h1, {31'h0, rsc});
  endtask : t_defaults
  task t_writes;
    acc(1, 0, OFS_OPMODE_CLKBUF, 32'hffff_ffff);
    acc(1, 0, OFS_PHY_LANE_DELTA, 32'hffff_ffff);
    acc(1, 3, OFS_PORT_TUNING, 32'hffff_ffff);
    acc(0, 0, OFS_OPMODE_CLKBUF, 32'h007f_0022);
    acc(0, 0, OFS_PHY_LANE_DELTA, 32'h0000_8000);
    acc(0, 3, OFS_PORT_TUNING, 32'h0079_0000);
  endtask : t_writes
  task t_loads;
    sb(0, OFS_PHY_LANE_DELTA, 32'hffff_ffff);
    acc(0, 0, OFS_PHY_LANE_DELTA, 32'hffff_807f);
    sb(2, OFS_PHY_LANE_DELTA, 32'h0000_007f);
    chk("delta", 32'h1ffff, {15'h0, delta});
    chk("lane2", 32'h7f, {25'h0, lane[20:14]});
    sb(0, OFS_PORT_TUNING, 32'h0000_0000);
    chk("rsc_load", 32'h0, {31'h0, rsc});
    sb(3, OFS_PORT_TUNING, 32'h0000_0103);
    chk("rsc_down", 32'h0, {31'h0, rsc});
    chk("off", 32'h8, {26'h0, port_off});
    chk("retrain", 32'h8, {26'h0, retrain_off});
    sb(1, OFS_PHY_TX_MARGIN, 32'h0000_1234);
    chk("margin", 32'h116b, {16'h0, margin});
    sb(0, OFS_PHY_TX_MARGIN, 32'hffff_1234);
    acc(0, 0, OFS_PHY_TX_MARGIN, 32'h0000_1234);
    sb(0, OFS_OPMODE_CLKBUF, 32'hffff_ffff);
    acc(0, 0, OFS_OPMODE_CLKBUF, 32'h0fff_01ff);
    chk("gated", 32'h0, {25'h0, clken});
    chk("lpss", 32'hf, {28'h0, lpss});
    sb(0, OFS_OPMODE_CLKBUF, 32'h002a_0000);
    chk("pairs", 32'h2a, {25'h0, clken});
  endtask : t_loads
  task t_variants;
    for (int i = 0; i < 4; i++)
    begin
      rst(i[1:0], i[0]);
      acc(0, 0, OFS_OPMODE_CLKBUF, EV[i]);
      chk("opm", {16'h0, EV[i][15:0]}, {16'h0, opm});
      chk("pair", {25'h0, i[0] ? 7'h0 : EV[i][22:16]}, {25'h0, clken});
    end
  endtask : t_variants
  task final_report;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // main sequence
  initial
  begin
    t_defaults;
    t_writes;
    t_loads;
    t_variants;
    final_report;
  end
  // watchdog, far beyond the roughly ninety cycles needed
  initial
  begin
    #100us;
    error_cnt++;
    final_report;
  end
endmodule : switch_phy_mode_config_bank_bench
